// [hw/sd_block_write.sv]
// Block write sequencer with forced-stop handling toward one SD memory card.
//
// Contract
// - Block count per request lies in 1..65535.
// - Blocks are 512 bytes, addressed by block number.
// - CMD24 per block up to 2, else CMD25.
// - Write mode 0 erase-first, 1 plain, else refused.
// - Removed card at start: stop-abort, no command.
// - Pending halt at start: clear it, stop-abort.
// - Software variant ignores the DMA transfer setting.
// - Halt command sets sticky state, arguments ignored.
// - Halt during data, except in a software transfer's last block: CMD12, abort, report stop-abort.
// - Halt after completion stays pending for next.
// - Halt sampled once at start before commands.
// - Software transfers check halt at block boundaries.
// - DMA transfers honour halt at any cycle in the data state.
// - Halt state cleared whenever halt handling runs.
// - After CMD12 abort, wait for card ready.
// - Zero-based card index, one card per request.
`timescale 1ns/1ps
module sd_block_write
   import sdw_pkg::*;
#(
   parameter int NUM_CARDS = 1
) (
   input wire logic clock,
   input wire logic nrst,
   // Request side
   input wire logic req_valid,
   input wire write_req_s req,
   output logic req_ready,
   output logic done,
   output req_status_e status,
   // Forced halt, one-cycle pulse from requester logic
   input wire logic forced_halt_request_cmd,
   input wire logic [31:0] halt_mode,
   input wire logic [31:0] halt_size,
   output logic halt_pending,
   // Write data from the requester
   input wire logic src_valid,
   input wire logic [`SDW_WORD_W-1:0] src_data,
   output logic src_ready,
   // Card command engine
   output logic cmd_valid,
   output card_cmd_s cmd,
   output logic [`SDW_CARD_IDX_W-1:0] card_sel,
   input wire logic cmd_done,
   input wire logic cmd_err,
   // Card data path
   output logic dat_valid,
   output logic [`SDW_WORD_W-1:0] dat_word,
   output logic dat_last,
   input wire logic dat_ready,
   input wire logic dat_crc_err,
   // Card pins
   input wire logic card_present_pin,
   input wire logic card_busy_pin
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation

   logic [1:0] pins_sync;
   logic card_present;
   logic card_busy;

   sdw_sync #(
      .WIDTH(2)
   ) u_pin_sync (
      .clock(clock),
      .nrst(nrst),
      .async_in({card_busy_pin, card_present_pin}),
      .sync_out(pins_sync)
   );

   assign card_present = pins_sync[0];
   assign card_busy = pins_sync[1];

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   seq_state_e state_q;
   write_req_s req_q;
   logic [15:0] blocks_left_q;
   logic [31:0] cur_block_q;
   logic [7:0] words_left_q;
   logic multi_q;
   logic dma_q;
   logic halt_q;
   logic halt_clear;
   logic fail_q;
   req_status_e result_q;
   logic stop_after_q;
   logic [1:0] settle_q;
   logic req_bad;
   logic dat_take;
   logic src_take;

   // Halt arguments carry no meaning; they are accepted and dropped
   logic unused_halt_args;
   assign unused_halt_args = ^{halt_mode, halt_size};

   assign dat_take = dat_valid && dat_ready;
   assign src_take = src_valid && src_ready;

   // Request screening: count range, mode code, card index
   always_comb begin
      req_bad = 1'b0;
      if (req.block_count < `SDW_COUNT_MIN) begin
         req_bad = 1'b1;
      end
      if (req.write_mode != `SDW_MODE_ERASE_FIRST && req.write_mode != `SDW_MODE_PLAIN) begin
         req_bad = 1'b1;
      end
      if (32'(req.card_idx) >= 32'(NUM_CARDS)) begin
         req_bad = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky forced-halt state

   // A new halt pulse beats a clear in the same cycle, so no halt is lost
   always_ff @(posedge clock) begin
      if (!nrst) begin
         halt_q <= 1'b0;
      end else if (forced_halt_request_cmd) begin
         halt_q <= 1'b1;
      end else if (halt_clear) begin
         halt_q <= 1'b0;
      end
   end

   assign halt_pending = halt_q;

   // Clear whenever the sequencer acts on the halt
   always_comb begin
      halt_clear = 1'b0;
      if (state_q == st_check && halt_q) begin
         halt_clear = 1'b1;
      end
      if (state_q == st_blk_end && halt_q && blocks_left_q != 16'h0000) begin
         halt_clear = 1'b1;
      end
      if (state_q == st_data && dma_q && halt_q) begin
         halt_clear = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Busy settle delay

   // Synced busy lags the pin by up to two cycles; without this hold-off
   // the busy state would read a stale low level and skip the wait
   always_ff @(posedge clock) begin
      if (!nrst) begin
         settle_q <= `SDW_BUSY_SETTLE;
      end else if (state_q != st_busy) begin
         settle_q <= `SDW_BUSY_SETTLE;
      end else if (settle_q != 2'h0) begin
         settle_q <= settle_q - 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_q <= st_idle;
         req_q <= '0;
         blocks_left_q <= 16'h0000;
         cur_block_q <= 32'h0000_0000;
         multi_q <= 1'b0;
         dma_q <= 1'b0;
         fail_q <= 1'b0;
         result_q <= ok_status;
         stop_after_q <= 1'b0;
      end else begin
         unique case (state_q)
            st_idle: begin
               if (req_valid && req_ready) begin
                  req_q <= req;
                  blocks_left_q <= req.block_count;
                  cur_block_q <= req.start_block;
                  multi_q <= (req.block_count > `SDW_SINGLE_MAX);
                  dma_q <= req.use_dma && !req.sw_variant;
                  fail_q <= 1'b0;
                  stop_after_q <= 1'b0;
                  if (req_bad) begin
                     result_q <= param_err_status;
                     state_q <= st_done;
                  end else begin
                     state_q <= st_check;
                  end
               end
            end
            // One look at card presence and halt before any command
            st_check: begin
               if (!card_present) begin
                  result_q <= stop_abort_status;
                  state_q <= st_done;
               end else if (halt_q) begin
                  result_q <= stop_abort_status;
                  state_q <= st_done;
               end else begin
                  state_q <= st_cmd;
               end
            end
            st_cmd: begin
               state_q <= st_cmd_wait;
            end
            st_cmd_wait: begin
               if (cmd_done) begin
                  if (cmd_err) begin
                     result_q <= write_err_status;
                     state_q <= multi_q ? st_stop : st_busy;
                  end else begin
                     state_q <= st_data;
                  end
               end
            end
            st_data: begin
               if (dma_q && halt_q) begin
                  result_q <= stop_abort_status;
                  fail_q <= 1'b1;
                  state_q <= st_stop;
               end else if (dat_take && dat_last) begin
                  blocks_left_q <= blocks_left_q - 16'h0001;
                  cur_block_q <= cur_block_q + 32'h0000_0001;
                  state_q <= st_blk_end;
               end
            end
            // Boundary between blocks: finish check, then halt check, then next block
            st_blk_end: begin
               if (dat_crc_err) begin
                  result_q <= write_err_status;
                  fail_q <= 1'b1;
                  state_q <= st_stop;
               end else if (blocks_left_q == 16'h0000) begin
                  result_q <= ok_status;
                  state_q <= multi_q ? st_stop : st_busy;
               end else if (halt_q) begin
                  result_q <= stop_abort_status;
                  fail_q <= 1'b1;
                  state_q <= st_stop;
               end else if (multi_q) begin
                  state_q <= st_data;
               end else begin
                  stop_after_q <= 1'b1;
                  state_q <= st_busy;
               end
            end
            st_stop: begin
               state_q <= st_stop_wait;
            end
            st_stop_wait: begin
               if (cmd_done) begin
                  if (cmd_err) begin
                     result_q <= write_err_status;
                  end
                  state_q <= st_busy;
               end
            end
            // Card busy must clear before reporting or next command
            st_busy: begin
               if (settle_q == 2'h0 && !card_busy) begin
                  if (stop_after_q && !fail_q) begin
                     stop_after_q <= 1'b0;
                     state_q <= st_cmd;
                  end else begin
                     state_q <= st_done;
                  end
               end
            end
            st_done: begin
               state_q <= st_idle;
            end
            default: begin
               state_q <= st_idle;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request handshake and completion

   always_ff @(posedge clock) begin
      if (!nrst) begin
         req_ready <= 1'b0;
         done <= 1'b0;
         status <= ok_status;
      end else begin
         req_ready <= (state_q == st_idle) && !(req_valid && req_ready);
         done <= (state_q == st_done);
         if (state_q == st_done) begin
            status <= result_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command issue

   // CMD24 per block or a single CMD25; CMD12 on stop
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cmd_valid <= 1'b0;
         cmd <= '0;
         card_sel <= '0;
      end else begin
         cmd_valid <= 1'b0;
         if (state_q == st_check) begin
            card_sel <= req_q.card_idx;
         end
         if (state_q == st_cmd) begin
            cmd_valid <= 1'b1;
            cmd.index <= multi_q ? `SDW_CMD_WRITE_MULTI : `SDW_CMD_WRITE_SINGLE;
            cmd.arg <= cur_block_q;
            cmd.pre_erase <= (req_q.write_mode == `SDW_MODE_ERASE_FIRST);
         end else if (state_q == st_stop) begin
            cmd_valid <= 1'b1;
            cmd.index <= `SDW_CMD_STOP;
            cmd.arg <= 32'h0000_0000;
            cmd.pre_erase <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data words toward the card

   // One-word stage; ready is registered, so throughput is one word per
   // two cycles, traded for fully registered outputs
   always_ff @(posedge clock) begin
      if (!nrst) begin
         dat_valid <= 1'b0;
         dat_word <= '0;
         dat_last <= 1'b0;
         src_ready <= 1'b0;
         words_left_q <= `SDW_WORDS_PER_BLOCK;
      end else if (state_q != st_data || (dma_q && halt_q)) begin
         dat_valid <= 1'b0;
         dat_last <= 1'b0;
         src_ready <= 1'b0;
         words_left_q <= `SDW_WORDS_PER_BLOCK;
      end else if (src_take) begin
         dat_valid <= 1'b1;
         dat_word <= src_data;
         dat_last <= (words_left_q == 8'h01);
         words_left_q <= words_left_q - 8'h01;
         src_ready <= 1'b0;
      end else if (dat_take) begin
         dat_valid <= 1'b0;
         dat_last <= 1'b0;
         src_ready <= !dat_last;
      end else if (!dat_valid && words_left_q != 8'h00) begin
         src_ready <= 1'b1;
      end
   end

endmodule // sd_block_write

// [hw/sdw_map.svh]
// Constant map for the block write sequencer: sizes, command indices, mode codes.
`ifndef SDW_MAP_SVH
`define SDW_MAP_SVH

// Data block geometry
`define SDW_BLOCK_BYTES 16'h0200
`define SDW_WORD_BYTES 16'h0004
`define SDW_WORDS_PER_BLOCK 8'h80

// Block count limits per request
`define SDW_COUNT_MIN 16'h0001
`define SDW_COUNT_MAX 16'hFFFF
`define SDW_SINGLE_MAX 16'h0002

// Card command indices
`define SDW_CMD_WRITE_SINGLE 6'h18
`define SDW_CMD_WRITE_MULTI 6'h19
`define SDW_CMD_STOP 6'h0C

// Cycles to wait in the busy state before the synced busy pin is trusted
`define SDW_BUSY_SETTLE 2'h3

// Write mode codes
`define SDW_MODE_ERASE_FIRST 32'h0000_0000
`define SDW_MODE_PLAIN 32'h0000_0001

// Card selection and data widths
`define SDW_CARD_IDX_W 4
`define SDW_WORD_W 32

`endif

// [hw/sdw_pkg.sv]
// Types shared by the block write sequencer and its users.
package sdw_pkg;
`include "sdw_map.svh"

   // One write request as handed in by the requester
   typedef struct packed {
      logic [`SDW_CARD_IDX_W-1:0] card_idx;
      logic [31:0] start_block;
      logic [15:0] block_count;
      logic [31:0] write_mode;
      logic use_dma;
      logic sw_variant;
   } write_req_s;

   // Command handed to the card command engine
   typedef struct packed {
      logic [5:0] index;
      logic [31:0] arg;
      logic pre_erase;
   } card_cmd_s;

   // Completion status of a request
   typedef enum logic [1:0] {
      ok_status = 2'b00,
      stop_abort_status = 2'b01,
      param_err_status = 2'b10,
      write_err_status = 2'b11
   } req_status_e;

   // Sequencer states
   typedef enum logic [3:0] {
      st_idle = 4'b0000,
      st_check = 4'b0001,
      st_cmd = 4'b0010,
      st_cmd_wait = 4'b0011,
      st_data = 4'b0100,
      st_blk_end = 4'b0101,
      st_stop = 4'b0110,
      st_stop_wait = 4'b0111,
      st_busy = 4'b1000,
      st_done = 4'b1001
   } seq_state_e;

endpackage

// [hw/sdw_sync.sv]
// Two-stage synchroniser for pin-level inputs, one chain per bit.
`timescale 1ns/1ps
module sdw_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clock) begin
            if (!nrst) begin
               meta_q[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               meta_q[i] <= async_in[i];
               sync_out[i] <= meta_q[i];
            end
         end
      end
   endgenerate

endmodule // sdw_sync

// [testbench/sd_block_write_asserts.sv]
// Checker for the block write sequencer port behaviour.
`timescale 1ns/1ps
module sd_block_write_asserts
   import sdw_pkg::*;
#(
   parameter int NUM_CARDS = 1
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic req_valid,
   input wire write_req_s req,
   input wire logic req_ready,
   input wire logic done,
   input wire req_status_e status,
   input wire logic forced_halt_request_cmd,
   input wire logic halt_pending,
   input wire logic cmd_valid,
   input wire card_cmd_s cmd,
   input wire logic dat_valid,
   input wire logic [31:0] dat_word,
   input wire logic dat_ready
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   logic take;
   // Request accepted this edge
   assign take = req_valid && req_ready;
   ////////////////////////////////////////////////////////////////////////////////
   property p_cnt_zero;
      take && req.block_count == 16'h0000 |-> ##2 done && status == param_err_status;
   endproperty
   a_cnt_zero: assert property (p_cnt_zero) else $error("zero count accepted");
   property p_mode_bad;
      take && req.block_count != 16'h0000 && req.write_mode > 32'h0000_0001
         |-> ##2 done && status == param_err_status;
   endproperty
   a_mode_bad: assert property (p_mode_bad) else $error("bad mode accepted");
   property p_card_rng;
      take && req.card_idx >= NUM_CARDS |-> ##2 done && status == param_err_status;
   endproperty
   a_card_rng: assert property (p_card_rng) else $error("bad card accepted");
   property p_halt_start;
      take && halt_pending && req.block_count != 16'h0000 && req.write_mode <= 32'h0000_0001
         && req.card_idx < NUM_CARDS |-> ##3 done && status == stop_abort_status;
   endproperty
   a_halt_start: assert property (p_halt_start) else $error("pending halt ignored");
   property p_no_cmd;
      take && halt_pending |-> !cmd_valid [*4];
   endproperty
   a_no_cmd: assert property (p_no_cmd) else $error("command after halt");
   property p_halt_set;
      forced_halt_request_cmd |=> halt_pending;
   endproperty
   a_halt_set: assert property (p_halt_set) else $error("halt not sticky");
   property p_cmd_idx;
      cmd_valid |-> cmd.index == 6'h18 || cmd.index == 6'h19 || cmd.index == 6'h0c;
   endproperty
   a_cmd_idx: assert property (p_cmd_idx) else $error("unknown command index");
   property p_dat_hold;
      dat_valid && !dat_ready |=> dat_valid && $stable(dat_word);
   endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("data word dropped");
   property p_halt_clr;
      done && status == stop_abort_status |-> !halt_pending;
   endproperty
   a_halt_clr: assert property (p_halt_clr) else $error("halt left set");
endmodule // sd_block_write_asserts

bind sd_block_write sd_block_write_asserts #(.NUM_CARDS(NUM_CARDS)) chk_i (.clock, .nrst,
   .req_valid, .req, .req_ready, .done, .status, .forced_halt_request_cmd, .halt_pending,
   .cmd_valid, .cmd, .dat_valid, .dat_word, .dat_ready);

// [testbench/sd_card_model.sv]
// Behavioural card model: command answers, data pacing and busy.
`timescale 1ns/1ps
module sd_card_model
   import sdw_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic cmd_valid,
   input wire card_cmd_s cmd,
   input wire logic dat_valid,
   input wire logic dat_last,
   input wire logic slow,
   input wire logic fail,
   output logic cmd_done,
   output logic cmd_err,
   output logic dat_ready,
   output logic dat_crc_err,
   output logic card_busy_pin
);
   logic [2:0] wait_q;
   logic [3:0] busy_q;
   logic stop_q;
   logic ph_q;
   // Slow mode stalls every other cycle, so the sequencer must hold data
   assign dat_ready = slow ? ph_q : 1'b1;
   assign dat_crc_err = 1'b0;
   assign card_busy_pin = busy_q != 4'h0;
   // Busy follows each programmed block and each stop command
   always_ff @(posedge clock) begin
      if (!nrst) begin
         wait_q <= 3'h0;
         busy_q <= 4'h0;
         stop_q <= 1'b0;
         ph_q <= 1'b0;
         cmd_done <= 1'b0;
         cmd_err <= 1'b0;
      end else begin
         ph_q <= !ph_q;
         stop_q <= cmd_valid ? cmd.index == 6'h0c : stop_q;
         wait_q <= cmd_valid ? (slow ? 3'h5 : 3'h2) : (wait_q != 3'h0 ? wait_q - 3'h1 : 3'h0);
         cmd_done <= wait_q == 3'h1;
         cmd_err <= wait_q == 3'h1 && fail && !stop_q;
         busy_q <= (dat_valid && dat_ready && dat_last) || (wait_q == 3'h1 && stop_q) ?
            4'h6 : (busy_q != 4'h0 ? busy_q - 4'h1 : 4'h0);
      end
   end
endmodule // sd_card_model

// [testbench/sd_block_write_bench.sv]
// Self-checking bench for the block write sequencer.
`timescale 1ns/1ps
module sd_block_write_bench import sdw_pkg::*;;
   logic clock, nrst, req_valid, fhr, present, slow, fail, req_ready, done, halt_pending;
   logic src_ready, cmd_valid, dat_valid, dat_last, dat_ready, cmd_done, cmd_err, crc, busy;
   logic [3:0] card_sel;
   logic [31:0] src_data, dat_word, lw;
   logic pe;
   write_req_s req;
   req_status_e status, rs;
   card_cmd_s cmd;
   logic [5:0] cq[$];
   logic [31:0] aq[$];
   int bad_count = 0, n_checks = 0, nw = 0, halt_at = -1;
   sd_block_write uut (.clock(clock), .nrst(nrst), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .done(done), .status(status), .forced_halt_request_cmd(fhr),
      .halt_mode(32'hdead_beef), .halt_size(32'h0000_ffff), .halt_pending(halt_pending),
      .src_valid(1'b1), .src_data(src_data), .src_ready(src_ready), .cmd_valid(cmd_valid),
      .cmd(cmd), .card_sel(card_sel), .cmd_done(cmd_done), .cmd_err(cmd_err),
      .dat_valid(dat_valid), .dat_word(dat_word), .dat_last(dat_last), .dat_ready(dat_ready),
      .dat_crc_err(crc), .card_present_pin(present), .card_busy_pin(busy));
   sd_card_model card (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
      .dat_valid(dat_valid), .dat_last(dat_last), .slow(slow), .fail(fail),
      .cmd_done(cmd_done), .cmd_err(cmd_err), .dat_ready(dat_ready), .dat_crc_err(crc),
      .card_busy_pin(busy));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Halt may strike at any word count; may come from interrupt context
   always @(posedge clock) begin
      fhr <= halt_at == nw;
      if (halt_at == nw) halt_at = -1;
      // Completion and each single-block command must wait out card busy
      if (done === 1'b1 || (cmd_valid === 1'b1 && cmd.index == 6'h18)) begin
         chk("busy", 1'b0, busy);
      end
      if (cmd_valid === 1'b1) begin
         if (cq.size() == 0) pe <= cmd.pre_erase;
         cq.push_back(cmd.index);
         aq.push_back(cmd.arg);
      end
      // Words reach the card in the order the source handed them over
      if (dat_valid === 1'b1 && dat_ready === 1'b1) begin
         if (nw > 0) chk("word", lw + 32'h0000_0001, dat_word);
         lw = dat_word;
         nw++;
      end
      if (src_ready) src_data <= src_data + 32'h0000_0001;
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (e !== g) begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // One request, held until taken, then wait for its end under a bound
   task automatic run(input logic [3:0] c, input logic [15:0] n, input logic [31:0] m,
      input logic d, s);
      int k;
      cq.delete();
      aq.delete();
      nw = 0;
      k = 0;
      req <= '{c, 32'h0000_0100, n, m, d, s};
      req_valid <= 1'b1;
      do @(posedge clock); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      while (done !== 1'b1 && k < 20000) begin
         @(posedge clock);
         k++;
      end
      chk("done", 1'b1, done);
      rs = status;
      repeat (4) @(posedge clock);
   endtask
   task automatic t_single();
      run(4'h0, 16'h0002, 32'h0000_0000, 1'b0, 1'b0);
      chk("status", ok_status, rs);
      chk("idx", 6'h18, cq[1]);
      chk("arg", 32'h0000_0101, aq[1]);
      chk("words", 32'h0000_0100, nw);
      chk("erase", 1'b1, pe);
      chk("sel", 32'h0, card_sel);
      $display("single done");
   endtask
   task automatic t_multi();
      slow = 1'b1;
      run(4'h0, 16'h0003, 32'h0000_0001, 1'b0, 1'b0);
      slow = 1'b0;
      chk("status", ok_status, rs);
      chk("first", 6'h19, cq[0]);
      chk("last", 6'h0c, cq[$]);
      chk("words", 32'h0000_0180, nw);
      chk("erase", 1'b0, pe);
      $display("multi done");
   endtask
   task automatic t_bad();
      for (int i = 0; i < 3; i++) begin
         run(i == 2, i == 0 ? 16'h0000 : 16'hffff, i == 1 ? 32'h0000_0002 : 32'h0, 1'b0, 1'b0);
         chk("status", param_err_status, rs);
         chk("cmds", 32'h0, cq.size());
      end
      $display("bad done");
   endtask
   task automatic t_absent();
      present <= 1'b0;
      repeat (4) @(posedge clock);
      run(4'h0, 16'h0001, 32'h0000_0000, 1'b0, 1'b0);
      present <= 1'b1;
      repeat (4) @(posedge clock);
      chk("status", stop_abort_status, rs);
      chk("cmds", 32'h0, cq.size());
      $display("absent done");
   endtask
   task automatic t_pending();
      halt_at = nw;
      repeat (3) @(posedge clock);
      chk("pend", 1'b1, halt_pending);
      run(4'h0, 16'h0001, 32'h0000_0000, 1'b0, 1'b0);
      chk("status", stop_abort_status, rs);
      chk("cmds", 32'h0, cq.size());
      chk("clear", 1'b0, halt_pending);
      $display("pending done");
   endtask
   task automatic t_halt(input logic sw);
      halt_at = 10;
      run(4'h0, 16'h0004, 32'h0000_0001, 1'b1, sw);
      chk("status", stop_abort_status, rs);
      chk("stop", 6'h0c, cq[$]);
      chk("clear", 1'b0, halt_pending);
      if (sw) chk("words", 32'h0000_0080, nw);
      else chk("early", 1'b1, nw < 128);
      $display("halt done");
   endtask
   task automatic t_err();
      fail = 1'b1;
      run(4'h0, 16'h0001, 32'h0000_0000, 1'b0, 1'b0);
      fail = 1'b0;
      chk("status", write_err_status, rs);
      run(4'h0, 16'h0001, 32'h0000_0000, 1'b0, 1'b0);
      chk("retry", ok_status, rs);
      $display("error done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Main sequence; the software variant ignores the DMA setting
   initial begin
      nrst = 1'b0;
      req_valid = 1'b0;
      req = '0;
      fhr = 1'b0;
      present = 1'b1;
      slow = 1'b0;
      fail = 1'b0;
      src_data = 32'h0;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      t_single();
      t_multi();
      t_bad();
      t_absent();
      t_pending();
      t_halt(1'b1);
      t_halt(1'b0);
      t_err();
      close_out();
   end
   // Whole run needs a few thousand cycles; this bound is generous
   initial begin
      #2_000_000;
      bad_count++;
      close_out();
   end
endmodule // sd_block_write_bench
